//--- ports_pkg.sv
// Package for the parallel port block: register map, field positions, reset values and carriers
`default_nettype none
package ports_pkg;
  // ****************************************************************
  // Register map (CPU byte addresses, 14-bit space)
  // ****************************************************************
  localparam logic [13:0] tone_port_latch_addr = 14'h0000;
  localparam logic [13:0] keyscan_port_latch_addr = 14'h0001;
  localparam logic [13:0] port_c_data_addr = 14'h0002;
  localparam logic [13:0] port_d_data_addr = 14'h0003;
  localparam logic [13:0] tone_port_direction_addr = 14'h0004;
  localparam logic [13:0] keyscan_port_direction_addr = 14'h0005;
  localparam logic [13:0] port_c_direction_addr = 14'h0006;
  localparam logic [13:0] port_d_direction_addr = 14'h0007;
  localparam logic [13:0] memory_and_irq_options_addr = 14'h3fdf;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int low_overlay_bit = 7;
  localparam int upper_overlay_bit = 6;
  localparam int sense_level_bit = 1;
  localparam int compare_bit = 6;
  localparam logic [7:0] direction_reset = 8'h00;
  localparam logic [7:0] latch_reset = 8'h00;
  localparam logic sense_level_reset = 1'b1;
  localparam logic [7:0] option_used_mask = 8'hc2;
  localparam logic [6:0] port_d_dir_mask = 7'h3f;
  // ****************************************************************
  // Tone timing
  // ****************************************************************
  localparam int tone_half_period_cycles = 16;
  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [13:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cpu_req_s;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_s;
  typedef enum logic [1:0] {
    irq_idle = 2'b00,
    irq_pending = 2'b01,
    irq_armed_wait = 2'b11
  } irq_state_e;
endpackage
`default_nettype wire

//--- tone_gen.sv
// Fixed-frequency tone divider for the upper port A pins
`default_nettype none
module tone_gen #(
  parameter int half_period = ports_pkg::tone_half_period_cycles
) (
  input wire logic mclk,
  input wire logic rst,
  output logic tone
);
  localparam int cw = (half_period > 1) ? $clog2(half_period) : 1;
  logic [cw-1:0] count;

  if (half_period < 1) begin : g_bad_half_period
    $error("tone_gen: half_period must be at least 1");
  end

  // Free-running divide of the bus clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count <= '0;
      tone <= 1'b0;
    end else if (count == cw'(half_period - 1)) begin
      count <= '0;
      tone <= ~tone;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule // tone_gen
`default_nettype wire

//--- parallel_ports.sv
// Four parallel ports with tone, keyscan interrupt merge and the option register
`default_nettype none
// Summary of operation
// - Direction bit one makes pin output
// - Output pin drives its latch value
// - Read gives latch for outputs, pin otherwise
// - Direction registers read back written value; port D reads bits 5-0 only, bit 6 zero
// - Reset clears every direction bit
// - Ports A-C eight bits, D seven
// - Tone option: tone when data and direction set
// - Wired-OR option removes low-side driver on port A pins 7-4 only
// - Keyscan inputs inverted, ORed into interrupt
// - Edge mode: one request per fall
// - Level mode: requests while any source low
// - Port B output disables pullup and interrupt
// - Keyscan interrupts enabled straight after reset
// - Reset keeps port C latch
// - Port D bit 6 reads compare pin
// - Port D is GPIO while serial disabled
// - Option bit 7 selects low overlay
// - Option bit 6 selects upper overlay
// - Option bits 5-2 and 0 read zero
// - Option bit 1 selects level sensing
// - Sensing bit set by reset, written once
// - Ports A and B at 0-1, 4-5
module parallel_ports #(
  parameter bit tone_option = 1'b1,
  parameter bit wired_or_option = 1'b0,
  parameter logic [7:0] keyscan_option = 8'hff,
  parameter int tone_half_period = ports_pkg::tone_half_period_cycles
) (
  input wire logic mclk,
  input wire logic rst,
  input wire ports_pkg::cpu_req_s cpu_req,
  output ports_pkg::cpu_req_s unused_echo,
  output logic [7:0] cpu_rdata,
  input wire logic [7:0] pin_a_in,
  output ports_pkg::pin_drive_s pin_a,
  input wire logic [7:0] pin_b_in,
  output ports_pkg::pin_drive_s pin_b,
  output logic [7:0] pin_b_pullup_en,
  input wire logic [7:0] pin_c_in,
  output ports_pkg::pin_drive_s pin_c,
  input wire logic [6:0] pin_d_in,
  output logic [6:0] pin_d_out,
  output logic [6:0] pin_d_oe,
  input wire logic irq_pin_n,
  input wire logic compare_output_pin,
  input wire logic serial_sync_en,
  input wire logic serial_async_en,
  input wire logic [5:0] serial_d_oe,
  input wire logic [5:0] serial_d_out,
  input wire logic irq_ack,
  output logic irq_request,
  output logic low_overlay_select,
  output logic upper_overlay_select,
  output logic sense_level
);
  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (tone_half_period < 1) begin : g_bad_half_period
    $error("parallel_ports: tone_half_period must be at least 1");
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [7:0] tone_port_latch;
  logic [7:0] tone_port_direction;
  logic [7:0] keyscan_port_latch;
  logic [7:0] keyscan_port_direction;
  logic [7:0] port_c_data;
  logic [7:0] port_c_direction;
  // Port D storage is seven bits; bit 6 is held at zero
  logic [6:0] port_d_data;
  logic [6:0] port_d_direction;
  logic sense_written;
  logic tone;

  // Pin synchronisers
  // Every pin and the interrupt line pass two flops before use;
  // idle levels after reset match the pulled-up lines, so no false edge
  logic [7:0] a_s1, a_s2, b_s1, b_s2, c_s1, c_s2;
  logic [6:0] d_s1, d_s2;
  logic irq_s1, irq_s2, cmp_s1, cmp_s2;

  function automatic logic hit(input ports_pkg::cpu_req_s r, input logic [13:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  // Read view: latch for outputs, synchronised pin for inputs
  function automatic logic [7:0] mix(input logic [7:0] lat, input logic [7:0] dir, input logic [7:0] pin);
    mix = (lat & dir) | (pin & ~dir);
  endfunction

  // Tone divider shared by the four upper port A pins
  tone_gen #(
    .half_period(tone_half_period)
  ) u_tone (
    .mclk(mclk),
    .rst(rst),
    .tone(tone)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      a_s1 <= 8'h00;
      a_s2 <= 8'h00;
      b_s1 <= 8'hff;
      b_s2 <= 8'hff;
      c_s1 <= 8'h00;
      c_s2 <= 8'h00;
      d_s1 <= 7'h00;
      d_s2 <= 7'h00;
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
    end else begin
      a_s1 <= pin_a_in;
      a_s2 <= a_s1;
      b_s1 <= pin_b_in;
      b_s2 <= b_s1;
      c_s1 <= pin_c_in;
      c_s2 <= c_s1;
      d_s1 <= pin_d_in;
      d_s2 <= d_s1;
      irq_s1 <= irq_pin_n;
      irq_s2 <= irq_s1;
      cmp_s1 <= compare_output_pin;
      cmp_s2 <= cmp_s1;
    end
  end

  // ****************************************************************
  // Data latches
  // ****************************************************************
  // Latches are written regardless of direction, so software can preload
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tone_port_latch <= ports_pkg::latch_reset;
      keyscan_port_latch <= ports_pkg::latch_reset;
      port_d_data <= ports_pkg::latch_reset[6:0];
    end else begin
      if (hit(cpu_req, ports_pkg::tone_port_latch_addr)) begin
        tone_port_latch <= cpu_req.wdata;
      end
      if (hit(cpu_req, ports_pkg::keyscan_port_latch_addr)) begin
        keyscan_port_latch <= cpu_req.wdata;
      end
      if (hit(cpu_req, ports_pkg::port_d_data_addr)) begin
        port_d_data <= cpu_req.wdata[6:0] & ports_pkg::port_d_dir_mask;
      end
    end
  end

  // No reset here: this latch powers up undefined and keeps its value
  always_ff @(posedge mclk) begin
    if (hit(cpu_req, ports_pkg::port_c_data_addr)) begin
      port_c_data <= cpu_req.wdata;
    end
  end

  // ****************************************************************
  // Direction registers
  // ****************************************************************
  // Direction bits reset to zero so every pin starts as an input
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tone_port_direction <= ports_pkg::direction_reset;
      keyscan_port_direction <= ports_pkg::direction_reset;
      port_c_direction <= ports_pkg::direction_reset;
      port_d_direction <= ports_pkg::direction_reset[6:0];
    end else begin
      if (hit(cpu_req, ports_pkg::tone_port_direction_addr)) begin
        tone_port_direction <= cpu_req.wdata;
      end
      if (hit(cpu_req, ports_pkg::keyscan_port_direction_addr)) begin
        keyscan_port_direction <= cpu_req.wdata;
      end
      if (hit(cpu_req, ports_pkg::port_c_direction_addr)) begin
        port_c_direction <= cpu_req.wdata;
      end
      if (hit(cpu_req, ports_pkg::port_d_direction_addr)) begin
        port_d_direction <= cpu_req.wdata[6:0] & ports_pkg::port_d_dir_mask;
      end
    end
  end

  // ****************************************************************
  // Option register
  // ****************************************************************
  // Overlay bits may be rewritten at any time; the sense bit
  // freezes after the first write of any value to this address
  // Overlay selects reset to ROM
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      low_overlay_select <= 1'b0;
      upper_overlay_select <= 1'b0;
      sense_level <= ports_pkg::sense_level_reset;
      sense_written <= 1'b0;
    end else if (hit(cpu_req, ports_pkg::memory_and_irq_options_addr)) begin
      low_overlay_select <= cpu_req.wdata[ports_pkg::low_overlay_bit];
      upper_overlay_select <= cpu_req.wdata[ports_pkg::upper_overlay_bit];
      if (!sense_written) begin
        sense_level <= cpu_req.wdata[ports_pkg::sense_level_bit];
        sense_written <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Full address decode; unmapped addresses read zero
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (cpu_req.addr)
      ports_pkg::tone_port_latch_addr: next_rdata = mix(tone_port_latch, tone_port_direction, a_s2);
      ports_pkg::keyscan_port_latch_addr: next_rdata = mix(keyscan_port_latch, keyscan_port_direction, b_s2);
      ports_pkg::port_c_data_addr: next_rdata = mix(port_c_data, port_c_direction, c_s2);
      // Bit 6 has no latch or enable; it only mirrors the compare pin
      ports_pkg::port_d_data_addr: begin
        next_rdata = mix({1'b0, port_d_data}, {1'b0, port_d_direction}, {1'b0, d_s2});
        next_rdata[ports_pkg::compare_bit] = cmp_s2;
      end
      ports_pkg::tone_port_direction_addr: next_rdata = tone_port_direction;
      ports_pkg::keyscan_port_direction_addr: next_rdata = keyscan_port_direction;
      ports_pkg::port_c_direction_addr: next_rdata = port_c_direction;
      ports_pkg::port_d_direction_addr: next_rdata = {1'b0, port_d_direction};
      ports_pkg::memory_and_irq_options_addr: begin
        next_rdata[ports_pkg::low_overlay_bit] = low_overlay_select;
        next_rdata[ports_pkg::upper_overlay_bit] = upper_overlay_select;
        next_rdata[ports_pkg::sense_level_bit] = sense_level;
        next_rdata = next_rdata & ports_pkg::option_used_mask;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // Registered read data: valid the cycle after rd
  // Zero when no read is strobed, so stale data never lingers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpu_rdata <= 8'h00;
      unused_echo <= '0;
    end else begin
      cpu_rdata <= cpu_req.rd ? next_rdata : 8'h00;
      unused_echo <= cpu_req;
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Port A upper pins: tone replaces the latch, and the wired-OR
  // option keeps the driver off whenever the pin would go low
  logic [7:0] next_a_out, next_a_oe;
  logic [6:0] next_d_out, next_d_oe;
  always_comb begin
    next_a_out = tone_port_latch;
    next_a_oe = tone_port_direction;
    for (int i = 4; i < 8; i++) begin
      if (tone_option && tone_port_latch[i] && tone_port_direction[i]) begin
        next_a_out[i] = tone;
      end
      if (wired_or_option) begin
        next_a_oe[i] = tone_port_direction[i] && next_a_out[i];
      end
    end
    next_d_out = port_d_data;
    next_d_oe = port_d_direction & ports_pkg::port_d_dir_mask;
    // Serial units own their lines while enabled
    if (serial_async_en) begin
      next_d_out[1:0] = serial_d_out[1:0];
      next_d_oe[1:0] = serial_d_oe[1:0];
    end
    if (serial_sync_en) begin
      next_d_out[5:2] = serial_d_out[5:2];
      next_d_oe[5:2] = serial_d_oe[5:2];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_a <= '0;
      pin_b <= '0;
      pin_c <= '0;
      pin_d_out <= 7'h00;
      pin_d_oe <= 7'h00;
      pin_b_pullup_en <= 8'h00;
    end else begin
      pin_a.out <= next_a_out;
      pin_a.oe <= next_a_oe;
      pin_b.out <= keyscan_port_latch;
      pin_b.oe <= keyscan_port_direction;
      pin_b_pullup_en <= keyscan_option & ~keyscan_port_direction;
      pin_c.out <= port_c_data;
      pin_c.oe <= port_c_direction;
      pin_d_out <= next_d_out;
      pin_d_oe <= next_d_oe;
    end
  end

  // ****************************************************************
  // External interrupt merge and sensing
  // ****************************************************************
  // Limitation: a port B pin re-enabled by clearing its direction bit
  // joins the merge at once, but its driven level arrives three cycles
  // later through the output flop and the synchroniser; software must
  // let the high latch value settle on the pin before the clear
  // Any merged source low pulls the request line low
  logic any_low, any_low_q;
  assign any_low = !irq_s2 || |(~b_s2 & keyscan_option & ~keyscan_port_direction);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      any_low_q <= 1'b0;
    end else begin
      any_low_q <= any_low;
    end
  end

  // Request latch; a new fall beats an acknowledge in the same cycle
  // Edge mode compares the merged level with the previous cycle;
  // any_low_q resets low, so a source already low at release
  // raises exactly one request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_request <= 1'b0;
    end else if (sense_level && any_low) begin
      irq_request <= 1'b1;
    end else if (any_low && !any_low_q) begin
      irq_request <= 1'b1;
    end else if (irq_ack) begin
      irq_request <= 1'b0;
    end
  end
endmodule // parallel_ports
`default_nettype wire

//--- ports_monitor.sv
// Concurrent checks on the parallel port block ports
`default_nettype none
module ports_monitor #(
  parameter logic [7:0] keyscan_option = 8'hff
) (
  input wire logic mclk,
  input wire logic rst,
  input wire ports_pkg::cpu_req_s cpu_req,
  input wire logic [7:0] cpu_rdata,
  input wire ports_pkg::pin_drive_s pin_a,
  input wire ports_pkg::pin_drive_s pin_b,
  input wire ports_pkg::pin_drive_s pin_c,
  input wire logic [7:0] pin_b_pullup_en,
  input wire logic [7:0] pin_b_in,
  input wire logic [6:0] pin_d_oe,
  input wire logic irq_pin_n,
  input wire logic irq_ack,
  input wire logic irq_request,
  input wire logic low_overlay_select,
  input wire logic upper_overlay_select,
  input wire logic sense_level
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Helpers
  // ****************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic opt_seen;
  logic opt_wr;
  assign opt_wr = cpu_req.wr && cpu_req.addr == ports_pkg::memory_and_irq_options_addr;
  // Remembers the first option write, after which the sense bit is frozen
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) opt_seen <= 1'b0;
    else if (opt_wr) opt_seen <= 1'b1;
  end
  sequence s_quiet;
    (irq_pin_n && &pin_b_in)[*4];
  endsequence
  sequence s_pin_low;
    (!irq_pin_n && &pin_b_in)[*8];
  endsequence
  // ****************
  // Assertions
  // ****************
  a_dir_to_oe: assert property (cpu_req.wr && cpu_req.addr == ports_pkg::tone_port_direction_addr |-> ##2
    pin_a.oe == $past(cpu_req.wdata, 2)) else $error("port A enables differ from written direction");
  a_reset_inputs: assert property (disable iff (1'b0) rst [*2] |->
    (pin_a.oe | pin_b.oe | pin_c.oe) == 8'h00 && pin_d_oe == 7'h00) else $error("pin driven in reset");
  a_cmp_undriven: assert property (pin_d_oe[6] == 1'b0) else $error("port D bit 6 driven");
  a_opt_zero: assert property ($past(cpu_req.rd) && $past(cpu_req.addr) == ports_pkg::memory_and_irq_options_addr
    |-> (cpu_rdata & 8'h3d) == 8'h00) else $error("unused option bits read non-zero");
  a_pullup_dir: assert property (!$past(rst) |-> pin_b_pullup_en == (keyscan_option & ~pin_b.oe))
    else $error("pullup does not follow direction");
  a_sense_once: assert property (opt_wr && opt_seen |=> $stable(sense_level)) else $error("sense bit rewritten");
  a_overlay_wr: assert property (opt_wr |=> low_overlay_select == $past(cpu_req.wdata[7]) &&
    upper_overlay_select == $past(cpu_req.wdata[6])) else $error("overlay selects not written");
  a_irq_raise: assert property (s_quiet ##1 (!irq_pin_n && !irq_ack)[*4] |-> irq_request)
    else $error("falling source raised no request");
  a_level_refire: assert property (s_pin_low ##0 (irq_ack && sense_level) |=> irq_request)
    else $error("level mode request dropped while source low");
  a_edge_single: assert property (s_pin_low ##0 (irq_ack && !sense_level) |=> !irq_request)
    else $error("edge mode raised a second request");
endmodule // ports_monitor
`default_nettype wire

//--- pin_world.sv
// Model of the board around the ports: keypad, pullups and floating lines
`default_nettype none
module pin_world (
  input wire logic mclk,
  input wire logic [30:0] oe,
  input wire logic [30:0] out,
  input wire logic [30:0] pull,
  input wire logic [30:0] ext_en,
  input wire logic [30:0] ext,
  output logic [30:0] level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [30:0] drift = 31'h0;
  // Floating lines toggle so a stale value never reads as valid
  always @(posedge mclk) drift <= ~drift;
  // Device drive wins, then the outside driver, then pullup, else floating
  always_comb level = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pull | drift));
endmodule // pin_world
`default_nettype wire

//--- parallel_ports_tb.sv
// Self-checking bench for the parallel port block
`default_nettype none
module parallel_ports_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [13:0] pa = ports_pkg::tone_port_latch_addr, pa_dir = ports_pkg::tone_port_direction_addr,
    pb = ports_pkg::keyscan_port_latch_addr, pb_dir = ports_pkg::keyscan_port_direction_addr,
    pc = ports_pkg::port_c_data_addr, pc_dir = ports_pkg::port_c_direction_addr,
    pd = ports_pkg::port_d_data_addr, pd_dir = ports_pkg::port_d_direction_addr,
    opt = ports_pkg::memory_and_irq_options_addr;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  ports_pkg::cpu_req_s cpu_req = '0;
  ports_pkg::pin_drive_s pin_a, pin_b, pin_c;
  logic [7:0] cpu_rdata, pin_b_pullup_en;
  logic [6:0] pin_d_out, pin_d_oe;
  logic [30:0] ext_en = '1;
  logic [30:0] ext = {7'h00, 8'h00, 8'hff, 8'ha5};
  logic [30:0] level;
  logic irq_pin_n = 1'b1, cmp_pin = 1'b0, irq_ack = 1'b0, irq_request, low_ov, up_ov, sense_level;
  logic [1:0] seen;
  logic [1:0] ser_en = 2'b00;
  int err_total = 0, comparisons = 0;
  initial begin
    forever #5 mclk = ~mclk;
  end
  pin_world partner (.mclk(mclk), .oe({pin_d_oe, pin_c.oe, pin_b.oe, pin_a.oe}),
    .out({pin_d_out, pin_c.out, pin_b.out, pin_a.out}), .pull({15'h0000, pin_b_pullup_en, 8'h00}),
    .ext_en(ext_en), .ext(ext), .level(level));
  parallel_ports #(.tone_half_period(2)) dut (.mclk(mclk), .rst(rst), .cpu_req(cpu_req), .unused_echo(),
    .cpu_rdata(cpu_rdata), .pin_a_in(level[7:0]), .pin_a(pin_a), .pin_b_in(level[15:8]), .pin_b(pin_b),
    .pin_b_pullup_en(pin_b_pullup_en), .pin_c_in(level[23:16]), .pin_c(pin_c), .pin_d_in(level[30:24]),
    .pin_d_out(pin_d_out), .pin_d_oe(pin_d_oe), .irq_pin_n(irq_pin_n), .compare_output_pin(cmp_pin),
    .serial_sync_en(ser_en[1]), .serial_async_en(ser_en[0]), .serial_d_oe(6'h2a), .serial_d_out(6'h15),
    .irq_ack(irq_ack), .irq_request(irq_request), .low_overlay_select(low_ov),
    .upper_overlay_select(up_ov), .sense_level(sense_level));
  // ****************
  // Tasks
  // ****************
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    cpu_req.wr <= 1'b0;
  endtask
  // Read data is registered, so it is sampled just after the edge that takes the strobe
  task automatic rd(input logic [13:0] a, input logic [7:0] exp);
    @(posedge mclk);
    cpu_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    cpu_req.rd <= 1'b0;
    #1 chk(cpu_rdata, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wait_irq();
    for (int n = 0; n < 20 && irq_request !== 1'b1; n++) cyc(1);
    chk(irq_request, 1'b1);
    if (irq_request !== 1'b1) report_and_stop();
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      cyc(1);
      chk(irq_request, 1'b0);
    end
  endtask
  task automatic ack();
    @(posedge mclk) irq_ack <= 1'b1;
    @(posedge mclk) irq_ack <= 1'b0;
    #1;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 4; i < 8; i++) rd(14'(i), 8'h00);
    rd(opt, 8'h02);
    chk(pin_b_pullup_en, 8'hff);
    wr(pa_dir, 8'h0f);
    wr(pa, 8'h3c);
    cyc(2);
    chk(pin_a.oe, 8'h0f);
    chk(pin_a.out & 8'h0f, 8'h0c);
    rd(pa, 8'hac);
    rd(pa_dir, 8'h0f);
    wr(pa_dir, 8'hf0);
    wr(pa, 8'h80);
    seen = 2'b00;
    repeat (12) begin
      cyc(1);
      seen[pin_a.out[7]] = 1'b1;
    end
    chk(seen, 2'b11);
    chk(pin_a.out & 8'h70, 8'h00);
    wr(opt, 8'hc0);
    rd(opt, 8'hc0);
    wr(opt, 8'h02);
    rd(opt, 8'h00);
    @(posedge mclk) irq_pin_n <= 1'b0;
    wait_irq();
    cyc(4);
    ack();
    quiet(10);
    @(posedge mclk) irq_pin_n <= 1'b1;
    cyc(4);
    @(posedge mclk) ext[11] <= 1'b0;
    wait_irq();
    ack();
    @(posedge mclk) ext[11] <= 1'b1;
    wr(pb, 8'h00);
    wr(pb_dir, 8'h08);
    quiet(10);
    chk(pin_b_pullup_en, 8'hf7);
    wr(pb, 8'h08);
    // Let the high level reach the synchronised pin before the clear
    cyc(1);
    wr(pb_dir, 8'h00);
    quiet(6);
    @(posedge mclk) cmp_pin <= 1'b1;
    wr(pc_dir, 8'hff);
    wr(pc, 8'h5a);
    wr(pd_dir, 8'hff);
    wr(pd, 8'hff);
    rd(pd_dir, 8'h3f);
    rd(pd, 8'h7f);
    chk({1'b0, pin_d_oe}, 8'h3f);
    chk(pin_c.out, 8'h5a);
    @(posedge mclk) ser_en <= 2'b11;
    cyc(2);
    chk({1'b0, pin_d_oe}, 8'h2a);
    chk({1'b0, pin_d_out}, 8'h15);
    @(posedge mclk) ser_en <= 2'b00;
    @(posedge mclk) rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    rd(pc_dir, 8'h00);
    wr(pc_dir, 8'hff);
    rd(pc, 8'h5a);
    wr(opt, 8'h42);
    rd(opt, 8'h42);
    wr(opt, 8'h80);
    rd(opt, 8'h82);
    @(posedge mclk) irq_pin_n <= 1'b0;
    wait_irq();
    cyc(4);
    ack();
    wait_irq();
    @(posedge mclk) irq_pin_n <= 1'b1;
    cyc(4);
    ack();
    quiet(6);
    report_and_stop();
  end
endmodule // parallel_ports_tb
bind parallel_ports ports_monitor #(.keyscan_option(keyscan_option)) mon (.mclk(mclk), .rst(rst),
  .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c),
  .pin_b_pullup_en(pin_b_pullup_en), .pin_b_in(pin_b_in), .pin_d_oe(pin_d_oe), .irq_pin_n(irq_pin_n),
  .irq_ack(irq_ack), .irq_request(irq_request), .low_overlay_select(low_overlay_select),
  .upper_overlay_select(upper_overlay_select), .sense_level(sense_level));
`default_nettype wire
